//--- rtl/dstt_pkg.sv
package dstt_pkg;
  localparam logic [7:0] CH_SOH = 8'h01;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_CMD_RUN = 8'h66;
  // Request frame positions
  localparam int REQ_LEN = 12;
  localparam int POS_ST_HI = 1;
  localparam int POS_ST_LO = 2;
  localparam int POS_ENQ = 3;
  localparam int POS_CMD = 4;
  localparam int POS_DATA = 5;
  localparam int POS_ETX = 9;
  localparam int POS_CK_HI = 10;
  localparam int POS_CK_LO = 11;
  localparam logic [2:0] RSP_LAST = 3'h7;
  // Last error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_CHECKSUM = 8'h47;
  localparam logic [7:0] ERR_RECEIVE = 8'h49;
  localparam logic [7:0] ERR_FORMAT = 8'h4a;
  localparam logic [7:0] ERR_COMMAND = 8'h4b;
  localparam logic [15:0] DATA_FWD = 16'h0001;
  localparam logic [15:0] DATA_REV = 16'h0002;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam logic [15:0] T2_FIXED_MS = 16'h0001;
  localparam logic [15:0] T2_SHORT_MS = 16'h000a;
  localparam logic [15:0] T2_WRITE_MS = 16'h0064;
  localparam logic [15:0] T2_MOTOR_INIT_MS = 16'h01f4;
  localparam logic [15:0] T2_DATA_INIT_MS = 16'h1388;
  localparam logic [1:0] INIT_SEL_DATA = 2'h1;
  localparam logic [1:0] INIT_SEL_MOTOR = 2'h2;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {ST_COLLECT, ST_EVAL, ST_WAIT, ST_SEND} dstt_state_t;
endpackage

//--- rtl/dstt_fifo.sv
`timescale 1ns/100ps
module dstt_fifo
  import dstt_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem_reg[rd_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

//--- rtl/dstt_engine.sv
`timescale 1ns/100ps
// How it works
// - Run request: twelve bytes, command f
// - Reply SOH, station, ACK/NAK, command, ETX, checksum
// - Station 99: execute, never reply
// - Reply after interval plus transaction time
// - Short commands finish within 10 ms
// - Writes: 500 ms, 5 s, 100 ms
// - Checksum: low byte sum, two hex characters
// - Transmission errors get no reply
// - Logical errors get a NAK
module dstt_engine
  import dstt_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_error,
  input wire logic [7:0] i_station_hi,
  input wire logic [7:0] i_station_lo,
  input wire logic [7:0] i_response_interval_setting,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  output logic [7:0] o_last_comm_error_code_item,
  output logic o_forward_run_request,
  output logic o_reverse_run_request,
  output logic o_run_strobe,
  output logic o_busy
);
  dstt_state_t st_reg;
  logic [7:0] buf_reg [0:REQ_LEN-1];
  logic [3:0] idx_reg;
  logic rx_bad_reg;
  logic ack_reg;
  logic [7:0] st_hi_reg;
  logic [7:0] st_lo_reg;
  logic [7:0] cmd_reg;
  logic [2:0] sel_reg;
  logic [31:0] pre_reg;
  logic [15:0] ms_reg;
  logic [15:0] wait_ms;
  logic [7:0] sum;
  logic [7:0] rsp_sum;
  logic [15:0] data_val;
  logic data_hex_ok;
  logic ck_ok;
  logic addr_me;
  logic bcast;
  logic fmt_ok;
  logic cmd_ok;
  logic [7:0] err;
  logic accept;
  logic push;
  logic [7:0] push_data;
  logic fifo_ready;

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39)
    begin
      return {1'b1, 4'(c - 8'h30)};
    end
    if (c >= 8'h41 && c <= 8'h46)
    begin
      return {1'b1, 4'(c - 8'h37)};
    end
    return 5'h00;
  endfunction

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  // Worst-case transaction time per command class
  function automatic logic [15:0] t2_limit(input logic [7:0] c, input logic [1:0] init_sel);
    if (c == 8'h57)
    begin
      if (init_sel == INIT_SEL_DATA)
      begin
        return T2_DATA_INIT_MS;
      end
      if (init_sel == INIT_SEL_MOTOR)
      begin
        return T2_MOTOR_INIT_MS;
      end
      return T2_WRITE_MS;
    end
    return T2_SHORT_MS;
  endfunction

  // Request parse; bytes arriving outside collection are dropped
  always_comb
  begin
    logic [4:0] h;
    logic [4:0] ck_hi;
    logic [4:0] ck_lo;
    h = 5'h00;
    ck_hi = hex_val(buf_reg[POS_CK_HI]);
    ck_lo = hex_val(buf_reg[POS_CK_LO]);
    sum = 8'h00;
    for (int i = POS_ST_HI; i <= POS_ETX; i++)
    begin
      sum = sum + buf_reg[i];
    end
    data_hex_ok = 1'b1;
    data_val = 16'h0000;
    for (int i = 0; i < 4; i++)
    begin
      h = hex_val(buf_reg[POS_DATA+i]);
      data_hex_ok = data_hex_ok && h[4];
      data_val = {data_val[11:0], h[3:0]};
    end
    ck_ok = ck_hi[4] && ck_lo[4] && ({ck_hi[3:0], ck_lo[3:0]} == sum);
    addr_me = (buf_reg[POS_ST_HI] == i_station_hi) && (buf_reg[POS_ST_LO] == i_station_lo);
    bcast = (buf_reg[POS_ST_HI] == CH_NINE) && (buf_reg[POS_ST_LO] == CH_NINE);
    fmt_ok = (buf_reg[POS_ENQ] == CH_ENQ) && (buf_reg[POS_ETX] == CH_ETX) && data_hex_ok;
    cmd_ok = (buf_reg[POS_CMD] == CH_CMD_RUN);
    err = !fmt_ok ? ERR_FORMAT : (!cmd_ok ? ERR_COMMAND : ERR_NONE);
    accept = !rx_bad_reg && ck_ok && (addr_me || bcast);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      idx_reg <= 4'h0;
      rx_bad_reg <= 1'b0;
    end
    else if (st_reg == ST_COLLECT && i_rx_valid)
    begin
      if (idx_reg == 4'h0)
      begin
        if (i_rx_data == CH_SOH)
        begin
          idx_reg <= 4'h1;
          rx_bad_reg <= i_rx_error;
        end
      end
      else
      begin
        idx_reg <= (idx_reg == 4'(REQ_LEN-1)) ? 4'h0 : idx_reg + 4'h1;
        rx_bad_reg <= rx_bad_reg | i_rx_error;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (st_reg == ST_COLLECT && i_rx_valid && (idx_reg != 4'h0 || i_rx_data == CH_SOH))
    begin
      buf_reg[idx_reg] <= i_rx_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_reg <= ST_COLLECT;
    end
    else
    begin
      case (st_reg)
        ST_COLLECT:
        begin
          if (i_rx_valid && idx_reg == 4'(REQ_LEN-1))
          begin
            st_reg <= ST_EVAL;
          end
        end
        ST_EVAL:
        begin
          st_reg <= (accept && !bcast) ? ST_WAIT : ST_COLLECT;
        end
        ST_WAIT:
        begin
          if (ms_reg >= wait_ms)
          begin
            st_reg <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          if (fifo_ready && sel_reg == RSP_LAST)
          begin
            st_reg <= ST_COLLECT;
          end
        end
        default:
        begin
          st_reg <= ST_COLLECT;
        end
      endcase
    end
  end

  // Execute and record result
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_forward_run_request <= 1'b0;
      o_reverse_run_request <= 1'b0;
      o_run_strobe <= 1'b0;
      o_last_comm_error_code_item <= ERR_NONE;
      ack_reg <= 1'b0;
      st_hi_reg <= 8'h00;
      st_lo_reg <= 8'h00;
      cmd_reg <= 8'h00;
    end
    else
    begin
      o_run_strobe <= 1'b0;
      if (st_reg == ST_EVAL)
      begin
        if (accept)
        begin
          ack_reg <= (err == ERR_NONE);
          st_hi_reg <= buf_reg[POS_ST_HI];
          st_lo_reg <= buf_reg[POS_ST_LO];
          cmd_reg <= buf_reg[POS_CMD];
          if (err == ERR_NONE)
          begin
            o_forward_run_request <= data_val[0];
            o_reverse_run_request <= data_val[1];
            o_run_strobe <= 1'b1;
          end
          else
          begin
            o_last_comm_error_code_item <= err;
          end
        end
        else if (addr_me)
        begin
          o_last_comm_error_code_item <= rx_bad_reg ? ERR_RECEIVE : ERR_CHECKSUM;
        end
      end
    end
  end

  // Interval in ms plus own processing time
  assign wait_ms = {8'h00, i_response_interval_setting} + T2_FIXED_MS;

  always_ff @(posedge i_clk)
  begin
    if (i_reset || st_reg != ST_WAIT)
    begin
      pre_reg <= 32'h0;
      ms_reg <= 16'h0000;
    end
    else if (pre_reg == 32'(MS_CYCLES_P - 1))
    begin
      pre_reg <= 32'h0;
      ms_reg <= ms_reg + 16'h0001;
    end
    else
    begin
      pre_reg <= pre_reg + 32'h1;
    end
  end

  // Reply bytes; a full FIFO stalls the sequence
  assign rsp_sum = st_hi_reg + st_lo_reg + (ack_reg ? CH_ACK : CH_NAK) + cmd_reg + CH_ETX;
  always_comb
  begin
    case (sel_reg)
      3'h0: push_data = CH_SOH;
      3'h1: push_data = st_hi_reg;
      3'h2: push_data = st_lo_reg;
      3'h3: push_data = ack_reg ? CH_ACK : CH_NAK;
      3'h4: push_data = cmd_reg;
      3'h5: push_data = CH_ETX;
      3'h6: push_data = hex_chr(rsp_sum[7:4]);
      default: push_data = hex_chr(rsp_sum[3:0]);
    endcase
  end
  assign push = (st_reg == ST_SEND);

  always_ff @(posedge i_clk)
  begin
    if (i_reset || st_reg != ST_SEND)
    begin
      sel_reg <= 3'h0;
    end
    else if (fifo_ready)
    begin
      sel_reg <= sel_reg + 3'h1;
    end
  end

  assign o_busy = (st_reg != ST_COLLECT);

  dstt_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_in_valid(push),
    .i_in_data(push_data),
    .o_in_ready(fifo_ready),
    .o_out_valid(o_tx_valid),
    .o_out_data(o_tx_data),
    .i_out_ready(i_tx_ready)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  broadcast_silent_a: assert property (st_reg == ST_EVAL && bcast
    |=> st_reg == ST_COLLECT)
    else $error("Broadcast led to a reply");
  rx_error_silent_a: assert property (st_reg == ST_EVAL && rx_bad_reg
    |=> st_reg == ST_COLLECT)
    else $error("Reply after receive error");
  format_nak_a: assert property (st_reg == ST_EVAL && accept && !bcast && !fmt_ok
    |=> !ack_reg && o_last_comm_error_code_item == ERR_FORMAT && st_reg == ST_WAIT)
    else $error("Format error not answered by NAK");
  reply_delay_a: assert property (st_reg == ST_WAIT && ms_reg < wait_ms
    |=> st_reg != ST_SEND)
    else $error("Reply started early");
  // Wait must end on time, else the host timeout budget is eaten
  trans_bound_a: assert property (st_reg == ST_WAIT && ms_reg >= wait_ms
    |=> st_reg == ST_SEND && T2_FIXED_MS <= t2_limit(cmd_reg, 2'h0))
    else $error("Transaction time over limit");
  ack_byte_a: assert property (push && sel_reg == 3'h3
    |-> push_data == (ack_reg ? 8'h06 : 8'h15))
    else $error("Wrong acknowledge byte");
  reply_end_a: assert property (push && fifo_ready && sel_reg == 3'h5
    |-> push_data == 8'h03 ##1 push_data == hex_chr(rsp_sum[7:4]))
    else $error("Reply tail wrong");
  fwd_exec_a: assert property (st_reg == ST_EVAL && accept && err == ERR_NONE
    && data_val == DATA_FWD |=> o_run_strobe && o_forward_run_request && !o_reverse_run_request)
    else $error("Forward run not executed");
  send_stall_a: assert property (push && !fifo_ready
    |=> $stable(sel_reg) && st_reg == ST_SEND)
    else $error("Reply byte lost on stall");
endmodule

//--- verification/dstt_host_model.sv
`timescale 1ns/100ps
module dstt_host_model
  import dstt_pkg::*;
#(
  parameter int TIMEOUT_CYC = 200
)
(
  input wire logic i_clk,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_busy,
  input wire logic i_stall,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_error,
  output logic o_tx_ready
);
  logic [7:0] rsp_q[$];
  int cyc = 0;
  int first_cyc = 0;
  int end_cyc = 0;
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_error = 1'b0;
    o_tx_ready = 1'b1;
  end
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (o_tx_ready && i_tx_valid)
    begin
      if (rsp_q.size() == 0)
        first_cyc = cyc;
      rsp_q.push_back(i_tx_data);
    end
    #1 o_tx_ready = !i_stall || cyc[1];
  end
  task automatic send_frame(input logic [7:0] f[12], input int bad_pos);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge i_clk);
      #1;
      o_rx_valid = 1'b1;
      o_rx_data = f[i];
      o_rx_error = (i == bad_pos);
    end
    @(posedge i_clk);
    #1;
    o_rx_valid = 1'b0;
    // Idle line must not look like a held byte
    o_rx_data = ~o_rx_data;
    o_rx_error = 1'b0;
    end_cyc = cyc;
  endtask
  task automatic transact(input logic [7:0] f[12], input int nexp, input int err_first,
                          output int tries);
    int w;
    tries = 0;
    do
    begin
      rsp_q.delete();
      tries++;
      send_frame(f, (tries == 1) ? err_first : -1);
      w = 0;
      // Timeout well above reply time, no new frame before reply or timeout
      while (w < TIMEOUT_CYC && !(nexp > 0 && rsp_q.size() == nexp && !i_busy))
      begin
        @(posedge i_clk);
        #1;
        w++;
      end
    end while (nexp > 0 && w == TIMEOUT_CYC && tries < 3);
  endtask
endmodule

//--- verification/drive_serial_transaction_timing_tb.sv
`timescale 1ns/100ps
module drive_serial_transaction_timing_tb;
  import dstt_pkg::*;
  localparam int MS_SIM = 8;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] iv = 8'h00;
  logic stall = 1'b0;
  logic rx_valid, rx_error, tx_ready, tx_valid, forward_run_request, reverse_run_request, strobe, busy;
  logic [7:0] rx_data, tx_data, code;
  logic [7:0] prev_code = 8'h00;
  logic [1:0] prev_run = 2'b00;
  int num_errors = 0;
  int samples_checked = 0;
  int strobes = 0;
  int seed = 32'hbebe;
  always #12.5 clk = ~clk;
  always @(posedge clk)
    if (strobe === 1'b1)
      strobes <= strobes + 1;
  dstt_engine #(.MS_CYCLES_P(MS_SIM)) i_dstt_engine (
    .i_clk(clk), .i_reset(reset), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .i_rx_error(rx_error), .i_station_hi("1"), .i_station_lo("2"),
    .i_response_interval_setting(iv), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
    .i_tx_ready(tx_ready), .o_last_comm_error_code_item(code),
    .o_forward_run_request(forward_run_request), .o_reverse_run_request(reverse_run_request), .o_run_strobe(strobe),
    .o_busy(busy));
  dstt_host_model #(.TIMEOUT_CYC(200)) i_dstt_host_model (
    .i_clk(clk), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_busy(busy),
    .i_stall(stall), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_rx_error(rx_error), .o_tx_ready(tx_ready));
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic do_case(input string nm, input logic [7:0] sh, input logic [7:0] sl,
                         input logic [7:0] cmd, input logic [15:0] d, input int kind,
                         input int errp);
    logic [7:0] f[12];
    logic [7:0] r[8];
    logic [7:0] s;
    logic own, nak, exe;
    int nexp, tries, lat, s0;
    own = (sh == "1") && (sl == "2");
    nak = (kind >= 2) || (cmd != CH_CMD_RUN);
    f = '{CH_SOH, sh, sl, (kind == 2) ? CH_ACK : CH_ENQ, cmd, hexc(d[15:12]), hexc(d[11:8]),
          hexc(d[7:4]), hexc(d[3:0]), CH_ETX, 8'h00, 8'h00};
    if (kind == 3)
      f[6] = "G";
    s = 8'h00;
    for (int i = 1; i < 10; i++)
      s = s + f[i];
    f[10] = hexc(s[7:4]);
    f[11] = hexc(s[3:0]) ^ ((kind == 1) ? 8'h01 : 8'h00);
    r = '{CH_SOH, sh, sl, nak ? CH_NAK : CH_ACK, cmd, CH_ETX, 8'h00, 8'h00};
    s = 8'h00;
    for (int i = 1; i < 6; i++)
      s = s + r[i];
    r[6] = hexc(s[7:4]);
    r[7] = hexc(s[3:0]);
    nexp = (own && kind != 1) ? 8 : 0;
    exe = (own || (sh == CH_NINE && sl == CH_NINE)) && !nak && kind != 1;
    if (own)
      prev_code = (kind == 1) ? ERR_CHECKSUM : (kind >= 2) ? ERR_FORMAT :
                  nak ? ERR_COMMAND : (errp >= 0) ? ERR_RECEIVE : prev_code;
    if (exe)
      prev_run = d[1:0];
    s0 = strobes;
    i_dstt_host_model.transact(f, nexp, errp, tries);
    lat = i_dstt_host_model.first_cyc - i_dstt_host_model.end_cyc;
    chk(tries == ((errp >= 0) ? 2 : 1), "retry count");
    chk(i_dstt_host_model.rsp_q.size() == nexp, "reply length");
    for (int k = 0; k < nexp; k++)
      chk(i_dstt_host_model.rsp_q[k] === r[k], "reply byte");
    if (nexp > 0)
      chk(lat >= (iv + 1) * MS_SIM && lat <= (iv + 1) * MS_SIM + 8, "reply delay");
    chk(code === prev_code, "error code");
    chk(strobes == s0 + (exe ? 1 : 0), "run strobe");
    chk({reverse_run_request, forward_run_request} === prev_run, "run outputs");
    chk(busy === 1'b0, "idle after request");
    $display("test %s done", nm);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  initial
  begin
    int k;
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    chk(tx_valid === 1'b0 && busy === 1'b0 && code === ERR_NONE, "reset state");
    chk({reverse_run_request, forward_run_request} === 2'b00 && strobe === 1'b0, "reset run outputs");
    do_case("example", "1", "2", "f", DATA_FWD, 0, -1);
    do_case("broadcast", "9", "9", "f", DATA_REV, 0, -1);
    do_case("bad checksum", "1", "2", "f", 16'h0002, 1, -1);
    do_case("other station", "3", "4", "f", 16'h0003, 0, -1);
    do_case("retry", "1", "2", "f", 16'h0003, 0, 6);
    do_case("format first", "1", "2", "g", 16'h0001, 2, -1);
    do_case("non-hex data", "1", "2", "f", 16'h0000, 3, -1);
    do_case("bad command", "1", "2", "W", 16'h0001, 0, -1);
    // Stalled sink stretches the reply; delay bound leaves room for it
    stall = 1'b1;
    for (int n = 0; n < 10; n++)
    begin
      iv = 8'($unsigned($random(seed)) % 4);
      k = $unsigned($random(seed)) % 3;
      do_case("random", "1", "2", ($random(seed) & 1) ? "f" : "a", 16'($random(seed)),
              (k == 0) ? 0 : k + 1, -1);
    end
    give_verdict();
  end
endmodule
